// ### hdl/ddr_burst_sram_bus_interface.sv
// Two-word burst double-data-rate SRAM bus interface, device side
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Write: address at command, words next cycle
// - Read: words on edges five and six
// - Clock stopped: inputs ignored, pins hold
// - Reset leaves device deselected, outputs off
// - Burst words at A then A+1
// - Data taken and launched on both edges
// - Low lane select writes its nine bits
// - All selects high writes nothing
// - Lane selects sampled per data slot
// - Read after write returns newest data
// - Finish pending reads, then release outputs
module ddr_burst_sram_bus_interface
  import ddr_burst_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Clock-stopped standby
  input wire logic i_clock_stop,
  // Command
  input wire logic i_load_select_n,
  input wire logic i_read_write,
  input wire logic [ADDR_W-1:0] i_addr,
  // Data pins, split into input, output and enable
  input wire logic [WORD_W-1:0] i_dq,
  input wire logic [LANES-1:0] i_byte_lane_write_select_n,
  output logic [WORD_W-1:0] o_dq,
  output logic o_dq_oe_n,
  // Posted write buffer has room
  output logic o_write_ready
);

  localparam int PTR_W = $clog2(BUF_DEPTH);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_chk
    $error("BUF_DEPTH must be a power of two, at least 2");
  end
  if (ADDR_W < 2) begin : g_chk_addr
    $error("ADDR_W must be at least 2");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Spread a lane enable over the bits of its lane
  function automatic logic [WORD_W-1:0] lane_bits(
    input logic [LANES-1:0] en
  );
    logic [WORD_W-1:0] b;
    b = '0;
    for (int l = 0; l < LANES; l++) begin
      b[l*LANE_W +: LANE_W] = {LANE_W{en[l]}};
    end
    return b;
  endfunction : lane_bits

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  phase_e phase;                          // Clock that rises next
  logic run;                              // Clocks are running
  logic rd_take;                          // Read command taken
  logic wr_take;                          // Write command taken
  logic [RD_AGES:1] rd_v;                 // Read in flight, by age
  logic [ADDR_W-1:0] rd_addr [1:RD_AGES]; // Its burst address
  logic [WR_AGES:1] wr_v;                 // Write in flight, by age
  logic [ADDR_W-1:0] wr_addr [1:WR_AGES]; // Its burst address
  logic mem_rd;                           // Array read this edge
  logic [ADDR_W-1:0] rd_word_addr;        // Word fetched this edge
  logic out_word;                         // A read word leaves now
  logic push_valid;                       // Write word to post
  logic push_ok;                          // Buffer takes it
  logic [ADDR_W-1:0] push_addr;           // Its word address
  logic buf_in_ready;                     // Room in the buffer
  logic drain_ready;                      // Array port is free
  logic pop;                              // Buffer head goes to array
  logic [ADDR_W-1:0] buf_addr [BUF_DEPTH];
  logic [WORD_W-1:0] buf_data [BUF_DEPTH];
  logic [LANES-1:0] buf_lane [BUF_DEPTH]; // Lanes to write
  logic [PTR_W-1:0] head;
  logic [PTR_W-1:0] tail;
  logic [PTR_W:0] count;
  logic [PTR_W:0] next_count;
  logic [WORD_W-1:0] next_byp_data;       // Newest posted bytes
  logic [LANES-1:0] next_byp_lane;        // Lanes they cover
  logic [WORD_W-1:0] byp_data;
  logic [LANES-1:0] byp_lane;
  logic [WORD_W-1:0] mem_rdata;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // A stopped clock freezes every stage, so pins keep their state
  assign run = !i_clock_stop;
  // Commands are only taken at a positive-clock rise; load select
  // high starts nothing whatever read/write select says
  assign rd_take = run && phase == PH_POS_RISE && !i_load_select_n
                   && i_read_write;
  assign wr_take = run && phase == PH_POS_RISE && !i_load_select_n
                   && !i_read_write;

  // Edge phase alternates between the two input clocks
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase <= PH_POS_RISE;
    end else if (run) begin
      phase <= (phase == PH_POS_RISE) ? PH_NEG_RISE : PH_POS_RISE;
    end
  end

  // ----------------------------------------------------------------
  // Operation pipelines, one stage per data edge
  // ----------------------------------------------------------------
  for (genvar k = 1; k <= RD_AGES; k++) begin : g_rd
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        rd_v[k] <= 1'b0;
      end else if (run) begin
        rd_v[k] <= (k == 1) ? rd_take : rd_v[(k > 1) ? k-1 : k];
      end
    end
    // Address rides along; no reset needed for data
    always_ff @(posedge i_clk) begin
      if (run) begin
        rd_addr[k] <= (k == 1) ? i_addr : rd_addr[(k > 1) ? k-1 : k];
      end
    end
  end

  for (genvar k = 1; k <= WR_AGES; k++) begin : g_wr
    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        wr_v[k] <= 1'b0;
      end else if (run) begin
        wr_v[k] <= (k == 1) ? wr_take : wr_v[(k > 1) ? k-1 : k];
      end
    end
    always_ff @(posedge i_clk) begin
      if (run) begin
        wr_addr[k] <= (k == 1) ? i_addr : wr_addr[(k > 1) ? k-1 : k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write capture into the posted write buffer
  // ----------------------------------------------------------------
  // First word at A on the positive rise, second at A+1 on the
  // negative rise of the next cycle; masks sampled per word
  assign push_addr = wr_v[WR_AGE_FIRST] ? wr_addr[WR_AGE_FIRST]
                     : wr_addr[WR_AGE_SECOND] + 1'b1;
  // A word with every lane deselected is never posted
  assign push_valid = run
    && (wr_v[WR_AGE_FIRST] || wr_v[WR_AGE_SECOND])
    && i_byte_lane_write_select_n != LANES_NONE;
  assign buf_in_ready = count < (PTR_W+1)'(BUF_DEPTH);
  assign push_ok = push_valid && buf_in_ready;

  // ----------------------------------------------------------------
  // Array port arbitration: reads first, writes drain when free
  // ----------------------------------------------------------------
  assign mem_rd = run && (rd_v[RD_AGE_FETCH0] || rd_v[RD_AGE_FETCH1]);
  assign rd_word_addr = rd_v[RD_AGE_FETCH0] ? rd_addr[RD_AGE_FETCH0]
                        : rd_addr[RD_AGE_FETCH1] + 1'b1;
  // Reads hold the port, so a long read stream stalls the drain
  // and the buffer really fills; the controller sees o_write_ready
  assign drain_ready = run && !mem_rd;
  assign pop = drain_ready && count != '0;
  assign next_count = count + (PTR_W+1)'(push_ok) - (PTR_W+1)'(pop);

  // Buffer storage; entries carry the word's own lane mask
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      buf_addr[tail] <= push_addr;
      buf_data[tail] <= i_dq;
      buf_lane[tail] <= ~i_byte_lane_write_select_n;
    end
  end

  // Buffer pointers and fill level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      head <= '0;
      tail <= '0;
      count <= '0;
      o_write_ready <= 1'b1;
    end else begin
      if (push_ok) begin
        tail <= tail + 1'b1;
      end
      if (pop) begin
        head <= head + 1'b1;
      end
      count <= next_count;
      o_write_ready <= next_count < (PTR_W+1)'(BUF_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Bypass: posted words newer than the array win, oldest first so
  // the newest entry overrides
  // ----------------------------------------------------------------
  always_comb begin
    logic [PTR_W-1:0] idx;
    idx = '0;
    next_byp_data = '0;
    next_byp_lane = '0;
    for (int i = 0; i < BUF_DEPTH; i++) begin
      idx = head + PTR_W'(i);
      if ((PTR_W+1)'(i) < count && buf_addr[idx] == rd_word_addr) begin
        next_byp_data = (next_byp_data & ~lane_bits(buf_lane[idx]))
                        | (buf_data[idx] & lane_bits(buf_lane[idx]));
        next_byp_lane = next_byp_lane | buf_lane[idx];
      end
    end
  end

  // Bypass held beside the array's read register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      byp_lane <= '0;
    end else if (mem_rd) begin
      byp_lane <= next_byp_lane;
      byp_data <= next_byp_data;
    end
  end

  // ----------------------------------------------------------------
  // Word array
  // ----------------------------------------------------------------
  burst_word_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .i_clk(i_clk),
    .i_en(mem_rd || pop),
    .i_we(!mem_rd),
    .i_addr(mem_rd ? rd_word_addr : buf_addr[head]),
    .i_wdata(buf_data[head]),
    .i_lane_en(buf_lane[head]),
    .o_rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  // Word A leaves on the negative rise of t+2, A+1 on the positive
  // rise of t+3; with no word due the pins are released
  assign out_word = run && (rd_v[RD_AGE_OUT0] || rd_v[RD_AGE_OUT1]);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_dq_oe_n <= 1'b1;
      o_dq <= '0;
    end else if (out_word) begin
      o_dq_oe_n <= 1'b0;
      o_dq <= (mem_rdata & ~lane_bits(byp_lane))
              | (byp_data & lane_bits(byp_lane));
    end else if (run) begin
      o_dq_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  reset_deselect_a: assert property (
    $fell(i_reset) |-> o_dq_oe_n && count == '0
  ) else $error("outputs driven after reset");

  read_latency_a: assert property (
    rd_take ##1 run [*5] |=> !o_dq_oe_n ##1 (!run || !o_dq_oe_n)
  ) else $error("read words not driven at edges five and six");

  drive_source_a: assert property (
    $fell(o_dq_oe_n) |-> $past(rd_v[RD_AGE_OUT0] || rd_v[RD_AGE_OUT1])
  ) else $error("pins driven with no read in flight");

  stop_hold_a: assert property (
    i_clock_stop |=> $stable(o_dq) && $stable(o_dq_oe_n)
                     && $stable(count) && $stable(rd_v)
  ) else $error("state changed while clocks stopped");

  second_word_a: assert property (
    mem_rd && !rd_v[RD_AGE_FETCH0]
      |-> rd_word_addr == rd_addr[RD_AGE_FETCH1] + 1'b1
  ) else $error("second burst word not at A+1");

  write_capture_a: assert property (
    run && wr_v[WR_AGE_FIRST] && push_valid && buf_in_ready && !pop
      |=> count == $past(count) + 1'b1
  ) else $error("first write word not posted");

  all_masked_a: assert property (
    run && (wr_v[WR_AGE_FIRST] || wr_v[WR_AGE_SECOND])
      && i_byte_lane_write_select_n == LANES_NONE
      |=> count == $past(count) - (PTR_W+1)'($past(pop))
  ) else $error("fully masked word was posted");

  lane_map_a: assert property (
    push_ok |=> buf_lane[$past(tail)] == ~$past(i_byte_lane_write_select_n)
  ) else $error("lane enables do not follow selects");

  release_a: assert property (
    run && !rd_v[RD_AGE_OUT0] && !rd_v[RD_AGE_OUT1] |=> o_dq_oe_n
  ) else $error("pins still driven after burst");

  read_seen_c: cover property (rd_take ##6 !o_dq_oe_n);
  write_seen_c: cover property (wr_take ##2 push_ok ##1 push_ok);
  bypass_hit_c: cover property (mem_rd && next_byp_lane != '0);
  buffer_full_c: cover property (!o_write_ready);

endmodule : ddr_burst_sram_bus_interface
`default_nettype wire

// ### hdl/ddr_burst_pkg.sv
// Constants and types shared by the burst SRAM bus interface and its array
package ddr_burst_pkg;

  // ----------------------------------------------------------------
  // Word and lane layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 36;        // One data word on the pins
  localparam int LANES = 4;          // Byte lanes per word
  localparam int LANE_W = 9;         // Bits per byte lane
  localparam int ADDR_W_DEF = 22;    // Word address width (4M words)
  localparam int BUF_DEPTH_DEF = 2;  // Posted write buffer entries

  // ----------------------------------------------------------------
  // Slot timing, counted in data edges after the command edge
  // ----------------------------------------------------------------
  localparam int WR_AGE_FIRST = 2;   // Age seen before first write word
  localparam int WR_AGE_SECOND = 3;  // Age seen before second write word
  localparam int WR_AGES = 3;        // Write pipeline length
  localparam int RD_AGE_FETCH0 = 4;  // Age when word A is fetched
  localparam int RD_AGE_FETCH1 = 5;  // Age when word A+1 is fetched
  localparam int RD_AGE_OUT0 = 5;    // Age before word A is driven
  localparam int RD_AGE_OUT1 = 6;    // Age before word A+1 is driven
  localparam int RD_AGES = 6;        // Read pipeline length

  // Lane selects all high means nothing to write
  localparam logic [LANES-1:0] LANES_NONE = 4'hF;

  // ----------------------------------------------------------------
  // Edge phase: which input clock rises at the coming edge
  // ----------------------------------------------------------------
  typedef enum logic {
    PH_POS_RISE,
    PH_NEG_RISE
  } phase_e;

endpackage : ddr_burst_pkg

// ### hdl/burst_word_array.sv
// Word array with per-lane write enables and registered read data
`timescale 1ns/100ps
`default_nettype none

module burst_word_array #(
  parameter int ADDR_W = 22,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  // Clock
  input wire logic i_clk,
  // Access port
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LANES*LANE_W-1:0] i_wdata,
  input wire logic [LANES-1:0] i_lane_en,
  // Read data, held until the next read
  output logic [LANES*LANE_W-1:0] o_rdata
);

  // Storage; contents are undefined after power-up
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ----------------------------------------------------------------
  // Lane writes: a lane whose enable is low keeps its old contents
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge i_clk) begin
      if (i_en && i_we && i_lane_en[g]) begin
        mem[i_addr][g*LANE_W +: LANE_W] <= i_wdata[g*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_en && !i_we) begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule : burst_word_array
`default_nettype wire

// ### tb/burst_controller_model.sv
// Memory controller model driving bursts into the SRAM interface
`timescale 1ns/100ps
`default_nettype none

module burst_controller_model
  import ddr_burst_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  // Clock, reset and standby
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clock_stop,
  // Device side of the data pins
  input wire logic [WORD_W-1:0] i_dq,
  input wire logic i_dq_oe_n,
  input wire logic i_write_ready,
  // Command and write data towards the device
  output logic o_load_select_n,
  output logic o_read_write,
  output logic [ADDR_W-1:0] o_addr,
  output logic [WORD_W-1:0] o_dq,
  output logic [LANES-1:0] o_byte_lane_write_select_n
);
  logic pos_next; // Coming edge is a positive-clock rise
  logic last_rd; // Previous burst was a read

  // -------------------------------------------------------------
  // Idle levels
  // -------------------------------------------------------------
  initial begin
    o_load_select_n = 1'b1;
    o_read_write = 1'b0;
    o_addr = '0;
    o_dq = 36'h5_A5A5_A5A5;
    o_byte_lane_write_select_n = LANES_NONE;
    last_rd = 1'b0;
  end

  // Phase tracks the device; stopped edges do not count
  always @(posedge i_clk) begin
    if (!i_clock_stop) begin
      pos_next <= i_reset ? 1'b1 : ~pos_next;
    end
  end

  // One counted edge, then the usual small drive delay
  task automatic step();
    do @(posedge i_clk); while (i_clock_stop === 1'b1);
    #1;
  endtask : step

  // -------------------------------------------------------------
  // One whole burst; read words and enables come back
  // -------------------------------------------------------------
  task automatic burst(input logic rd, input logic [ADDR_W-1:0] a,
      input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1,
      input logic [LANES-1:0] s0, input logic [LANES-1:0] s1,
      output logic [WORD_W-1:0] r0, output logic [WORD_W-1:0] r1,
      output logic [2:0] oe);
    int n;
    if (!rd && last_rd) begin
      repeat (4) step();
    end
    n = 0;
    while ((pos_next !== 1'b1 || i_write_ready !== 1'b1) && n < 20) begin
      step();
      n++;
    end
    o_load_select_n = 1'b0;
    o_read_write = rd;
    o_addr = a;
    step();
    // Released command lines show the inverse, not the old value
    o_load_select_n = 1'b1;
    o_read_write = ~rd;
    o_addr = ~a;
    step();
    if (!rd) begin
      o_dq = w0;
      o_byte_lane_write_select_n = s0;
      step();
      o_dq = w1;
      o_byte_lane_write_select_n = s1;
      step();
      o_dq = ~w1;
      o_byte_lane_write_select_n = LANES_NONE;
    end else begin
      repeat (4) step();
      r0 = i_dq;
      oe[0] = i_dq_oe_n;
      step();
      r1 = i_dq;
      oe[1] = i_dq_oe_n;
      step();
      oe[2] = i_dq_oe_n;
    end
    last_rd = rd;
  endtask : burst
endmodule : burst_controller_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the burst SRAM bus interface
`timescale 1ns/100ps
`default_nettype none

module testbench import ddr_burst_pkg::*;;
  logic clk; // 40 MHz system clock
  logic reset; // Synchronous reset
  logic clock_stop; // Standby request
  logic ctl_load_n, ctl_rw, load_n, rw; // Command from the model
  logic [5:0] ctl_addr, addr;
  logic [WORD_W-1:0] ctl_dq, dev_dq, pin_dq; // Data pins
  logic [LANES-1:0] ctl_sel;
  logic dev_oe_n, dev_ready;
  int errors, checks;

  // Shared pin: whoever has the enable drives it
  assign pin_dq = (dev_oe_n == 1'b0) ? dev_dq : ctl_dq;
  // While stopped the command lines carry a write to garbage
  assign load_n = clock_stop ? 1'b0 : ctl_load_n;
  assign rw = clock_stop ? 1'b0 : ctl_rw;
  assign addr = clock_stop ? ~ctl_addr : ctl_addr;

  ddr_burst_sram_bus_interface #(.ADDR_W(6), .BUF_DEPTH(2))
      u_ddr_burst_sram_bus_interface (
    .i_clk(clk), .i_reset(reset), .i_clock_stop(clock_stop),
    .i_load_select_n(load_n), .i_read_write(rw), .i_addr(addr),
    .i_dq(pin_dq), .i_byte_lane_write_select_n(ctl_sel),
    .o_dq(dev_dq), .o_dq_oe_n(dev_oe_n), .o_write_ready(dev_ready));

  burst_controller_model #(.ADDR_W(6)) u_burst_controller_model (
    .i_clk(clk), .i_reset(reset), .i_clock_stop(clock_stop),
    .i_dq(pin_dq), .i_dq_oe_n(dev_oe_n), .i_write_ready(dev_ready),
    .o_load_select_n(ctl_load_n), .o_read_write(ctl_rw),
    .o_addr(ctl_addr), .o_dq(ctl_dq),
    .o_byte_lane_write_select_n(ctl_sel));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic check(input logic [WORD_W-1:0] got,
      input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [WORD_W-1:0] w0,
      input logic [WORD_W-1:0] w1, input logic [LANES-1:0] s0,
      input logic [LANES-1:0] s1);
    logic [WORD_W-1:0] r0, r1;
    logic [2:0] oe;
    u_burst_controller_model.burst(1'b0, a, w0, w1, s0, s1, r0, r1, oe);
  endtask : wr

  // Read a burst; drive only on the two data slots, then release
  task automatic rd_chk(input logic [5:0] a, input logic [WORD_W-1:0] e0,
      input logic [WORD_W-1:0] e1);
    logic [WORD_W-1:0] r0, r1;
    logic [2:0] oe;
    u_burst_controller_model.burst(1'b1, a, '0, '0, LANES_NONE,
        LANES_NONE, r0, r1, oe);
    check(r0, e0);
    check(r1, e1);
    check({33'h0, oe}, 36'h4);
  endtask : rd_chk

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic test_reset();
    repeat (6) begin
      @(posedge clk);
      #1;
      check({34'h0, dev_oe_n, dev_ready}, 36'h3);
      check(dev_dq, 36'h0);
    end
    $display("reset test done");
  endtask : test_reset

  // Top address: second word wraps to address zero
  task automatic test_wrap();
    wr(6'h3F, 36'h1_2345_6789, 36'h8_7654_3210, 4'h0, 4'h0);
    wr(6'h00, 36'hC_3C3C_3C3C, 36'h0_0000_0011, 4'hF, 4'h0);
    rd_chk(6'h3F, 36'h1_2345_6789, 36'h8_7654_3210);
    rd_chk(6'h00, 36'h8_7654_3210, 36'h0_0000_0011);
    $display("wrap test done");
  endtask : test_wrap

  // Each lane alone on word A, nothing at all on word A+1
  task automatic test_lanes();
    logic [WORD_W-1:0] m;
    for (int l = 0; l < LANES; l++) begin
      m = 36'h1FF << (LANE_W * l);
      wr(6'h20, 36'h0, 36'h3_0303_0303, 4'h0, 4'h0);
      wr(6'h20, 36'hA_5A5A_5A5A, 36'hF_FFFF_FFFF, ~(4'h1 << l),
          LANES_NONE);
      rd_chk(6'h20, 36'hA_5A5A_5A5A & m, 36'h3_0303_0303);
    end
    $display("lane test done");
  endtask : test_lanes

  // Reads straight after writes must see the newest bytes
  task automatic test_bypass();
    wr(6'h30, 36'h1_1111_1111, 36'h2_2222_2222, 4'h0, 4'h0);
    rd_chk(6'h30, 36'h1_1111_1111, 36'h2_2222_2222);
    wr(6'h30, 36'hE_EEEE_EEEE, 36'hD_DDDD_DDDD, 4'hE, 4'h7);
    rd_chk(6'h30, 36'h1_1111_10EE, 36'hD_DA22_2222);
    $display("bypass test done");
  endtask : test_bypass

  // Stop the clocks while word A is on the pins
  task automatic test_standby();
    logic [WORD_W-1:0] r0, r1;
    logic [2:0] oe;
    int n;
    wr(6'h11, 36'h1_2345_6789, 36'hE_DCBA_9876, 4'h0, 4'h0);
    fork
      u_burst_controller_model.burst(1'b1, 6'h11, '0, '0, LANES_NONE,
          LANES_NONE, r0, r1, oe);
      begin
        n = 0;
        do begin
          @(posedge clk);
          #1;
          n++;
        end while (dev_oe_n !== 1'b0 && n < 40);
        clock_stop = 1'b1;
        repeat (4) begin
          @(posedge clk);
          #1;
          check({35'h0, dev_oe_n}, 36'h0);
          check(dev_dq, 36'h1_2345_6789);
        end
        clock_stop = 1'b0;
      end
    join
    check(r0, 36'h1_2345_6789);
    check(r1, 36'hE_DCBA_9876);
    check({33'h0, oe}, 36'h4);
    rd_chk(6'h11, 36'h1_2345_6789, 36'hE_DCBA_9876);
    $display("standby test done");
  endtask : test_standby

  // -------------------------------------------------------------
  // Verdict, clock, watchdog and main sequence
  // -------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    checks = 0;
    reset = 1'b1;
    clock_stop = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    test_reset();
    test_wrap();
    test_lanes();
    test_bypass();
    test_standby();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
